// ---- can_gc_defines.svh ----
/*
  Offsets, field positions, reset values and timing counts for the
  CAN general control block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CAN_GC_DEFINES_SVH
`define CAN_GC_DEFINES_SVH

// byte addresses: control index 0xAB, status word chosen beside it
`define GC_CTRL_INDEX       8'hAB
`define GC_CTRL_ADDR        10'h2AC
`define GC_STAT_ADDR        10'h2A8
`define GC_CTRL_RESET       8'h00

`define GC_BIT_ABORT        7
`define GC_BIT_OVERLOAD     6
`define GC_BIT_TIME_TRIG    5
`define GC_BIT_SYNC_EOF     4
`define GC_BIT_LISTEN       3
`define GC_BIT_TEST         2
`define GC_BIT_RUN          1
`define GC_BIT_SOFT_RESET   0

`define GC_STAT_ACTIVE      2
`define GC_STAT_OVERLOAD    6
`define GC_STAT_TX_BUSY     4
`define GC_STAT_RX_BUSY     3

`define GC_START_CYCLES     2
`define GC_OBJECTS          15

`endif

// ---- can_gc_pkg.sv ----
/*
  Types for the CAN general control block.
  Assumes nothing of its surroundings.
*/
package can_gc_pkg;
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_STARTING,
    ST_RUNNING,
    ST_STOPPING
  } run_state_type;
endpackage

// ---- can_gc_object_active.sv ----
/*
  Per message object active bits with set, clear and abort.
  Assumes one clock, asynchronous active-high reset.
*/
`timescale 1ns/10ps
`include "can_gc_defines.svh"
module can_gc_object_active (
  input  wire logic                    clk_i,      // clock
  input  wire logic                    rst_i,      // async reset
  input  wire logic                    soft_rst_i, // soft reset
  input  wire logic                    abort_i,    // abort level
  input  wire logic                    frozen_i,   // controller stopped
  input  wire logic [`GC_OBJECTS-1:0]  set_i,      // software enable
  input  wire logic [`GC_OBJECTS-1:0]  clr_i,      // object done
  output logic      [`GC_OBJECTS-1:0]  active_o    // active bits
);
  logic [`GC_OBJECTS-1:0] active_reg;
  logic [`GC_OBJECTS-1:0] active_next;

  always_comb begin
    active_next = active_reg;
    if (soft_rst_i || abort_i) begin
      active_next = '0;
    end else begin
      active_next = active_reg | set_i;
      if (!frozen_i) begin
        active_next = active_next & ~clr_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_reg <= '0;
    end else begin
      active_reg <= active_next;
    end
  end

  assign active_o = active_reg;
endmodule // can_gc_object_active

// ---- can_general_control.sv ----
/*
  General control of the CAN controller: control register on an
  Avalon-MM slave, run/standby sequencing, clock gate enable, abort,
  overload request, time-trigger capture and listen-only controls.
  Assumes a CAN engine beside it that reports frame events as pulses.
*/
// The implementer's own choice: the Avalon-MM interface to the registers.
// Summary of operation
// - abort bit clears every message object's active bit.
// - abort bit stays set until software writes zero.
// - abort drops pending sends; the frame on the bus finishes.
// - overload bit sends one overload frame after next reception.
// - overload bit clears itself when the overload frame starts.
// - bit 5 enables time-triggered mode; clear disables its features.
// - with sync bit zero, timer captured at start of frame.
// - with sync bit one, timer captured on last end-of-frame bit.
// - run bit activates controller and ungates its clock.
// - clearing run lets the current frame finish before stopping.
// - stopped controller is frozen; done pulses do not clear object active bits.
// - standby drives the transmit output recessive continuously.
// - standby disables receiver and stops the controller clock.
// - registers stay accessible while controller is disabled.
// - the state machine needs two clocks after run before operating.
// - all control register bits reset to zero.
// - listen-only: monitor only, no ack or send, counters frozen.
// - read-only active flag reports the true operating state.
// - time-triggered mode sends each frame once, no retry.
// - the 16-bit timer counts only after the controller is run.
`timescale 1ns/10ps
`include "can_gc_defines.svh"
module can_general_control (
  input  wire logic                    MCLK_I,           // 100 MHz clock
  input  wire logic                    SYS_RST_I,        // async reset
  input  wire logic [9:0]              AVS_ADDRESS_I,    // byte address
  input  wire logic                    AVS_READ_I,       // read strobe
  input  wire logic                    AVS_WRITE_I,      // write strobe
  input  wire logic [3:0]              AVS_BYTEENABLE_I, // byte lanes
  input  wire logic [31:0]             AVS_WRITEDATA_I,  // write data
  output logic      [31:0]             AVS_READDATA_O,   // read data
  output logic                         AVS_WAITREQUEST_O,// wait request
  output logic                         AVS_RESPONSE_O,   // 1 = unmapped
  input  wire logic                    FRAME_BUSY_I,     // frame on bus
  input  wire logic                    TX_PENDING_I,     // send queued
  input  wire logic                    TX_DONE_I,        // tx done pulse
  input  wire logic                    RX_DONE_I,        // rx done pulse
  input  wire logic                    SOF_I,            // start of frame
  input  wire logic                    EOF_LAST_I,       // last EOF bit
  input  wire logic                    OVL_START_I,      // overload begins
  input  wire logic                    OVL_END_I,        // overload ends
  input  wire logic                    TX_BIT_I,         // engine tx bit
  input  wire logic [`GC_OBJECTS-1:0]  OBJ_ENABLE_I,     // sw object enable
  input  wire logic [`GC_OBJECTS-1:0]  OBJ_DONE_I,       // object finished
  output logic      [`GC_OBJECTS-1:0]  OBJECT_ACTIVE_O,  // object active
  output logic                         CAN_TX_O,         // tx pin
  output logic                         CLK_GATE_EN_O,    // engine clock on
  output logic                         ENGINE_RUN_O,     // engine may step
  output logic                         RX_ENABLE_O,      // receiver on
  output logic                         TX_ALLOWED_O,     // may transmit
  output logic                         ACK_ALLOWED_O,    // may acknowledge
  output logic                         ERR_CNT_FREEZE_O, // counters hold
  output logic                         RETRY_ALLOWED_O,  // auto retransmit
  output logic                         DROP_PENDING_O,   // abort queue
  output logic                         OVERLOAD_SEND_O,  // send overload
  output logic                         SOFT_RESET_O,     // engine reset
  output logic                         TEST_MODE_O,      // factory test
  output logic                         TIME_TRIGGER_O,   // time-trigger mode
  output logic      [15:0]             TIMER_O,          // 16-bit timer
  output logic      [15:0]             TRIG_CAPTURE_O    // captured time
);
  logic [7:0]                   ctrl_reg;
  logic [7:0]                   ctrl_next;
  can_gc_pkg::run_state_type    state_reg;
  can_gc_pkg::run_state_type    state_next;
  logic [1:0]                   start_cnt_reg;
  logic [1:0]                   start_cnt_next;
  logic                         ovl_armed_reg;
  logic                         ovl_armed_next;
  logic                         ovl_flag_reg;
  logic                         ovl_flag_next;
  logic [15:0]                  timer_reg;
  logic [15:0]                  timer_next;
  logic [15:0]                  capture_reg;
  logic [15:0]                  capture_next;
  logic [31:0]                  rdata_reg;
  logic [31:0]                  rdata_next;
  logic                         resp_reg;
  logic                         resp_next;
  logic                         ack_reg;
  logic                         ack_next;
  logic                         req;
  logic                         hit_ctrl;
  logic                         hit_stat;
  logic                         wr_ctrl;
  logic                         running;
  logic                         active;
  logic [7:0]                   status;

  assign req      = (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
  assign hit_ctrl = AVS_ADDRESS_I == `GC_CTRL_ADDR;
  assign hit_stat = AVS_ADDRESS_I == `GC_STAT_ADDR;
  // bus stays live in every run state
  assign wr_ctrl  = req && AVS_WRITE_I && hit_ctrl
                    && AVS_BYTEENABLE_I[0];
  assign running  = state_reg == can_gc_pkg::ST_RUNNING;
  assign active   = running || state_reg == can_gc_pkg::ST_STOPPING;

  // one wait cycle, then answer
  always_comb begin
    ack_next  = req;
    resp_next = resp_reg;
    rdata_next = rdata_reg;
    if (req) begin
      resp_next  = !(hit_ctrl || hit_stat);
      rdata_next = 32'h0000_0000;
      if (AVS_READ_I && hit_ctrl) begin
        rdata_next[7:0] = ctrl_reg;
      end else if (AVS_READ_I && hit_stat) begin
        rdata_next[7:0] = status;
      end
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ack_reg   <= 1'b0;
      resp_reg  <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= ack_next;
      resp_reg  <= resp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
  assign AVS_READDATA_O    = rdata_reg;
  assign AVS_RESPONSE_O    = resp_reg;

  // read-only status word: run state and frame activity
  always_comb begin
    status = 8'h00;
    status[`GC_STAT_ACTIVE]   = active;
    status[`GC_STAT_OVERLOAD] = ovl_flag_reg;
    status[`GC_STAT_TX_BUSY]  = active && FRAME_BUSY_I && TX_PENDING_I;
    status[`GC_STAT_RX_BUSY]  = active && FRAME_BUSY_I;
  end

  // control register
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = AVS_WRITEDATA_I[7:0];
    end else begin
      ctrl_next[`GC_BIT_SOFT_RESET] = 1'b0;
    end
    // hardware clear wins only once the frame actually starts
    // a write in the same cycle is a fresh request and is kept
    if (OVL_START_I && ovl_armed_reg && !wr_ctrl) begin
      ctrl_next[`GC_BIT_OVERLOAD] = 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ctrl_reg <= `GC_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // run/standby sequencing
  always_comb begin
    state_next     = state_reg;
    start_cnt_next = start_cnt_reg;
    unique case (state_reg)
      can_gc_pkg::ST_STANDBY: begin
        if (ctrl_reg[`GC_BIT_RUN]) begin
          state_next     = can_gc_pkg::ST_STARTING;
          start_cnt_next = 2'(`GC_START_CYCLES - 1);
        end
      end
      can_gc_pkg::ST_STARTING: begin
        if (!ctrl_reg[`GC_BIT_RUN]) begin
          state_next = can_gc_pkg::ST_STANDBY;
        end else if (start_cnt_reg == 2'h0) begin
          state_next = can_gc_pkg::ST_RUNNING;
        end else begin
          start_cnt_next = start_cnt_reg - 2'h1;
        end
      end
      can_gc_pkg::ST_RUNNING: begin
        if (!ctrl_reg[`GC_BIT_RUN]) begin
          state_next = can_gc_pkg::ST_STOPPING;
        end
      end
      // stopping waits for the frame on the bus to end
      can_gc_pkg::ST_STOPPING: begin
        if (ctrl_reg[`GC_BIT_RUN]) begin
          state_next = can_gc_pkg::ST_RUNNING;
        end else if (!FRAME_BUSY_I) begin
          state_next = can_gc_pkg::ST_STANDBY;
        end
      end
    endcase
    if (ctrl_reg[`GC_BIT_SOFT_RESET]) begin
      state_next     = can_gc_pkg::ST_STANDBY;
      start_cnt_next = 2'h0;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_reg     <= can_gc_pkg::ST_STANDBY;
      start_cnt_reg <= 2'h0;
    end else begin
      state_reg     <= state_next;
      start_cnt_reg <= start_cnt_next;
    end
  end

  // overload request, timer and time-trigger capture
  always_comb begin
    ovl_armed_next = ovl_armed_reg;
    ovl_flag_next  = ovl_flag_reg;
    timer_next     = timer_reg;
    capture_next   = capture_reg;
    if (!ctrl_reg[`GC_BIT_OVERLOAD]) begin
      ovl_armed_next = 1'b0;
    end else if (RX_DONE_I && active) begin
      ovl_armed_next = 1'b1;
    end
    if (OVL_START_I && ovl_armed_reg) begin
      ovl_armed_next = 1'b0;
      ovl_flag_next  = 1'b1;
    end else if (OVL_END_I) begin
      ovl_flag_next = 1'b0;
    end
    // timer rolls over freely; it holds while the engine is stopped
    if (active) begin
      timer_next = timer_reg + 16'h0001;
    end
    if (active && ctrl_reg[`GC_BIT_TIME_TRIG]) begin
      if (!ctrl_reg[`GC_BIT_SYNC_EOF] && SOF_I) begin
        capture_next = timer_reg;
      end else if (ctrl_reg[`GC_BIT_SYNC_EOF] && EOF_LAST_I) begin
        capture_next = timer_reg;
      end
    end
    if (ctrl_reg[`GC_BIT_SOFT_RESET]) begin
      ovl_armed_next = 1'b0;
      ovl_flag_next  = 1'b0;
      timer_next     = 16'h0000;
      capture_next   = 16'h0000;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ovl_armed_reg <= 1'b0;
      ovl_flag_reg  <= 1'b0;
      timer_reg     <= 16'h0000;
      capture_reg   <= 16'h0000;
    end else begin
      ovl_armed_reg <= ovl_armed_next;
      ovl_flag_reg  <= ovl_flag_next;
      timer_reg     <= timer_next;
      capture_reg   <= capture_next;
    end
  end

  // frozen when stopped; done pulses still clear during frame finish
  can_gc_object_active objects (
    .clk_i      (MCLK_I),
    .rst_i      (SYS_RST_I),
    .soft_rst_i (ctrl_reg[`GC_BIT_SOFT_RESET]),
    .abort_i    (ctrl_reg[`GC_BIT_ABORT]),
    .frozen_i   (!active),
    .set_i      (OBJ_ENABLE_I),
    .clr_i      (OBJ_DONE_I),
    .active_o   (OBJECT_ACTIVE_O)
  );

  // standby: recessive pin, receiver off, engine clock gated
  assign CAN_TX_O         = active ? TX_BIT_I : 1'b1;
  assign CLK_GATE_EN_O    = state_reg != can_gc_pkg::ST_STANDBY;
  assign ENGINE_RUN_O     = active;
  assign RX_ENABLE_O      = active;
  assign TX_ALLOWED_O     = running && !ctrl_reg[`GC_BIT_LISTEN]
                            && !ctrl_reg[`GC_BIT_ABORT];
  assign ACK_ALLOWED_O    = active && !ctrl_reg[`GC_BIT_LISTEN];
  assign ERR_CNT_FREEZE_O = ctrl_reg[`GC_BIT_LISTEN];
  assign RETRY_ALLOWED_O  = !ctrl_reg[`GC_BIT_TIME_TRIG];
  // frame in progress is left alone; only the queue is dropped
  assign DROP_PENDING_O   = ctrl_reg[`GC_BIT_ABORT];
  assign OVERLOAD_SEND_O  = ovl_armed_reg && active;
  assign SOFT_RESET_O     = ctrl_reg[`GC_BIT_SOFT_RESET];
  // factory test bit passes through; software keeps it clear
  assign TEST_MODE_O      = ctrl_reg[`GC_BIT_TEST];
  assign TIME_TRIGGER_O   = ctrl_reg[`GC_BIT_TIME_TRIG];
  assign TIMER_O          = timer_reg;
  assign TRIG_CAPTURE_O   = capture_reg;
endmodule // can_general_control

// ---- can_gc_assertions.sv ----
/* Port assertions for the CAN general control block.
   Assumes a bind onto can_general_control, one clock domain. */
`timescale 1ns/10ps
`include "can_gc_defines.svh"
module can_gc_assertions (
  input wire logic                   MCLK_I,            // clock
  input wire logic                   SYS_RST_I,         // reset
  input wire logic                   AVS_READ_I,        // read
  input wire logic                   AVS_WRITE_I,       // write
  input wire logic                   AVS_WAITREQUEST_O, // wait
  input wire logic                   FRAME_BUSY_I,      // frame on
  input wire logic [`GC_OBJECTS-1:0] OBJECT_ACTIVE_O,   // objects
  input wire logic                   CAN_TX_O,          // tx pin
  input wire logic                   CLK_GATE_EN_O,     // clock on
  input wire logic                   ENGINE_RUN_O,      // running
  input wire logic                   RX_ENABLE_O,       // receiver
  input wire logic                   TX_ALLOWED_O,      // may send
  input wire logic                   ACK_ALLOWED_O,     // may ack
  input wire logic                   ERR_CNT_FREEZE_O,  // listen
  input wire logic                   DROP_PENDING_O,    // abort
  input wire logic                   SOFT_RESET_O,      // soft reset
  input wire logic [15:0]            TIMER_O            // timer
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  property p_ab; DROP_PENDING_O |=> OBJECT_ACTIVE_O == '0; endproperty
  a_ab: assert property (p_ab) else $error("abort kept objects");
  property p_hold;
    DROP_PENDING_O && !(AVS_WRITE_I && AVS_WAITREQUEST_O) |=> DROP_PENDING_O;
  endproperty
  a_hold: assert property (p_hold) else $error("abort cleared");
  property p_start;
    $rose(CLK_GATE_EN_O) |-> !ENGINE_RUN_O ##1 !ENGINE_RUN_O ##1 ENGINE_RUN_O;
  endproperty
  a_start: assert property (p_start) else $error("start delay");
  property p_stop;
    ENGINE_RUN_O && FRAME_BUSY_I && !SOFT_RESET_O
      |=> ENGINE_RUN_O || SOFT_RESET_O;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped in frame");
  property p_stby;
    !CLK_GATE_EN_O |-> CAN_TX_O && !RX_ENABLE_O && !ENGINE_RUN_O;
  endproperty
  a_stby: assert property (p_stby) else $error("standby");
  property p_lsn;
    ERR_CNT_FREEZE_O |-> !TX_ALLOWED_O && !ACK_ALLOWED_O;
  endproperty
  a_lsn: assert property (p_lsn) else $error("listen sends");
  property p_tmr;
    !CLK_GATE_EN_O && !SOFT_RESET_O && !AVS_WRITE_I |=> $stable(TIMER_O);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer in standby");
  property p_srst; $rose(SOFT_RESET_O) |=> !SOFT_RESET_O; endproperty
  a_srst: assert property (p_srst) else $error("soft reset held");
  property p_bus;
    $rose(AVS_READ_I) || $rose(AVS_WRITE_I)
      |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer");
endmodule // can_gc_assertions

// ---- can_gc_bus_model.sv ----
/* Far side model: other nodes sending frames, overload on request.
   Assumes start_i pulses while idle and len_i holds during a frame. */
`timescale 1ns/10ps
module can_gc_bus_model (
  input  wire logic       clk_i,       // clock
  input  wire logic       rst_i,       // reset
  input  wire logic       start_i,     // begin a frame
  input  wire logic [5:0] len_i,       // frame cycles
  input  wire logic       ovl_req_i,   // overload wanted
  output logic            busy_o,      // frame on bus
  output logic            sof_o,       // start of frame
  output logic            eof_last_o,  // last eof bit
  output logic            rx_done_o,   // frame received
  output logic            ovl_start_o, // overload begins
  output logic            ovl_end_o,   // overload ends
  output logic            tx_bit_o     // changing bit pattern
);
  logic [5:0] cnt_reg;
  logic [1:0] ovl_reg;
  assign busy_o = (cnt_reg != 6'h00) || (ovl_reg != 2'h0);
  assign sof_o = (cnt_reg != 6'h00) && (cnt_reg == len_i);
  assign eof_last_o = (cnt_reg == 6'h01);
  assign rx_done_o = eof_last_o;
  assign ovl_start_o = (ovl_reg == 2'h3);
  assign ovl_end_o = (ovl_reg == 2'h1);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 6'h00;
      ovl_reg <= 2'h0;
      tx_bit_o <= 1'b1;
    end else begin
      tx_bit_o <= ~tx_bit_o;
      if (start_i && cnt_reg == 6'h00) cnt_reg <= len_i;
      else if (cnt_reg != 6'h00) cnt_reg <= cnt_reg - 6'h01;
      if (ovl_reg != 2'h0) ovl_reg <= ovl_reg - 2'h1;
      else if (ovl_req_i && cnt_reg == 6'h00) ovl_reg <= 2'h3;
    end
  end
endmodule // can_gc_bus_model

// ---- tb.sv ----
/* Self-checking bench for can_general_control with a bus model.
   Assumes the design files and can_gc_defines.svh on the path. */
`timescale 1ns/10ps
`include "can_gc_defines.svh"
module tb;
  logic                   clk, rst, rd, wr, start, tpend, sync, busy, sof;
  logic                   eofl, rxd, ovs, ove, txb, wreq, rsp, cantx, gate;
  logic                   run, rxen, tx_done_flag, ackok, frz, retry, drop, ovsend;
  logic                   srst, tmode, tmtrig;
  logic [5:0]             len;
  logic [7:0]             d;
  logic [9:0]             addr;
  logic [`GC_OBJECTS-1:0] oen, odone, oact, ov;
  logic [15:0]            timer, cap, t_cap, t0;
  logic [31:0]            wdata, rdata, q;
  int                     fail_count, cmp_count, ovl_seen, rx_seen, rx0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  can_general_control i_can_general_control (
    .MCLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hF), .AVS_WRITEDATA_I(wdata),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .AVS_RESPONSE_O(rsp),
    .FRAME_BUSY_I(busy), .TX_PENDING_I(tpend), .TX_DONE_I(1'b0),
    .RX_DONE_I(rxd), .SOF_I(sof), .EOF_LAST_I(eofl), .OVL_START_I(ovs),
    .OVL_END_I(ove), .TX_BIT_I(txb), .OBJ_ENABLE_I(oen), .OBJ_DONE_I(odone),
    .OBJECT_ACTIVE_O(oact), .CAN_TX_O(cantx), .CLK_GATE_EN_O(gate),
    .ENGINE_RUN_O(run), .RX_ENABLE_O(rxen), .TX_ALLOWED_O(tx_done_flag),
    .ACK_ALLOWED_O(ackok), .ERR_CNT_FREEZE_O(frz), .RETRY_ALLOWED_O(retry),
    .DROP_PENDING_O(drop), .OVERLOAD_SEND_O(ovsend), .SOFT_RESET_O(srst),
    .TEST_MODE_O(tmode), .TIME_TRIGGER_O(tmtrig), .TIMER_O(timer),
    .TRIG_CAPTURE_O(cap));
  can_gc_bus_model i_can_gc_bus_model (
    .clk_i(clk), .rst_i(rst), .start_i(start), .len_i(len),
    .ovl_req_i(ovsend), .busy_o(busy), .sof_o(sof), .eof_last_o(eofl),
    .rx_done_o(rxd), .ovl_start_o(ovs), .ovl_end_o(ove), .tx_bit_o(txb));
  // timer value seen in the cycle of the capture event
  always @(negedge clk) begin
    if (sync ? eofl : sof) t_cap <= timer;
    if (ovs) ovl_seen++;
    if (rxd) rx_seen++;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %0h want %0h", $time, g, e);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h000000, v};
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      $display("unexpected at %0t: bus answer timed out", $time);
    end
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(q, {24'h000000, e});
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic frame(input logic [5:0] l);
    @(posedge clk);
    len <= l;
    start <= 1'b1;
    tpend <= 1'($urandom);
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b0 && n < 100);
    if (n >= 100) begin
      fail_count++;
      $display("unexpected at %0t: bus never went idle", $time);
    end
  endtask
  task automatic opulse(input logic [14:0] en, input logic [14:0] dn);
    @(posedge clk);
    oen <= en;
    odone <= dn;
    @(posedge clk);
    oen <= '0;
    odone <= '0;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    rst = 1'b1;
    {rd, wr, start, tpend, sync} = 5'h00;
    {addr, wdata, len, oen, odone} = '0;
    void'($urandom(32'h6F1C));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(`GC_CTRL_ADDR, `GC_CTRL_RESET);
    rdc(10'h000, 8'h00);
    chk(rsp, 1'b1);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom) & 8'h38;
      xfer(1'b1, `GC_CTRL_ADDR, d);
      rdc(`GC_CTRL_ADDR, d);
      chk(frz, d[3]);
      chk(tmtrig, d[5]);
    end
    $display("register test done");
    xfer(1'b1, `GC_CTRL_ADDR, 8'h02);
    ticks(4);
    chk(run, 1'b1);
    xfer(1'b0, `GC_STAT_ADDR, 8'h00);
    chk(q[`GC_STAT_ACTIVE], 1'b1);
    t0 = timer;
    ticks(5);
    chk(timer !== t0, 1'b1);
    for (int s = 0; s < 3; s++) begin
      sync = s[0];
      t0 = cap;
      xfer(1'b1, `GC_CTRL_ADDR, s == 2 ? 8'h02 : {3'h1, s[0], 4'h2});
      frame(6'd20);
      idle();
      chk(cap, s == 2 ? t0 : t_cap);
      chk(retry, s == 2);
    end
    chk({ackok, tx_done_flag}, 2'h3);
    $display("time trigger test done");
    xfer(1'b1, `GC_CTRL_ADDR, 8'h42);
    rdc(`GC_CTRL_ADDR, 8'h42);
    ovl_seen = 0;
    frame(6'd20);
    idle();
    ticks(8);
    chk(ovl_seen, 1);
    rdc(`GC_CTRL_ADDR, 8'h02);
    $display("overload test done");
    ov = 15'($urandom) | 15'h0001;
    opulse(ov, 15'h0000);
    rx0 = rx_seen;
    frame(6'd30);
    xfer(1'b1, `GC_CTRL_ADDR, 8'h82);
    ticks(1);
    chk(oact, 15'h0000);
    chk(tx_done_flag, 1'b0);
    chk(drop, 1'b1);
    idle();
    chk(rx_seen, rx0 + 1);
    rdc(`GC_CTRL_ADDR, 8'h82);
    $display("abort test done");
    xfer(1'b1, `GC_CTRL_ADDR, 8'h02);
    opulse(ov, 15'h0000);
    frame(6'd30);
    xfer(1'b1, `GC_CTRL_ADDR, 8'h00);
    ticks(1);
    chk(run, 1'b1);
    idle();
    ticks(2);
    chk({run, gate, rxen, cantx}, 4'h1);
    xfer(1'b0, `GC_STAT_ADDR, 8'h00);
    chk(q[`GC_STAT_ACTIVE], 1'b0);
    opulse(15'h0000, 15'h7FFF);
    ticks(1);
    chk(oact, ov);
    chk(tmode, 1'b0);
    $display("standby test done");
    xfer(1'b1, `GC_CTRL_ADDR, 8'h21);
    ticks(3);
    rdc(`GC_CTRL_ADDR, 8'h20);
    chk({srst, oact, timer}, 32'h00000000);
    $display("soft reset test done");
    final_report();
  end
endmodule // tb
bind can_general_control can_gc_assertions i_can_gc_assertions (
  .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .FRAME_BUSY_I(FRAME_BUSY_I), .OBJECT_ACTIVE_O(OBJECT_ACTIVE_O),
  .CAN_TX_O(CAN_TX_O), .CLK_GATE_EN_O(CLK_GATE_EN_O),
  .ENGINE_RUN_O(ENGINE_RUN_O), .RX_ENABLE_O(RX_ENABLE_O),
  .TX_ALLOWED_O(TX_ALLOWED_O), .ACK_ALLOWED_O(ACK_ALLOWED_O),
  .ERR_CNT_FREEZE_O(ERR_CNT_FREEZE_O), .DROP_PENDING_O(DROP_PENDING_O),
  .SOFT_RESET_O(SOFT_RESET_O), .TIMER_O(TIMER_O));
